// ===== hdl/flash_host_ctrl.sv
// host controller for a byte-wide page programmed flash
// assumes a synchronous register port and flash pins sampled on i_clock
`timescale 1ns/1ps
module flash_host_ctrl #(
	parameter int unsigned LOAD_TIMEOUT = flash_host_pkg::LOAD_TIMEOUT_CYC,
	parameter int unsigned POLL_LIMIT   = flash_host_pkg::ERASE_CYC
) (
	// clock and reset
	input  wire logic                                 i_clock,
	input  wire logic                                 i_reset_n,
	// software register port
	input  wire logic [flash_host_pkg::REG_ADDR_W-1:0] i_reg_addr,
	input  wire logic [flash_host_pkg::REG_DATA_W-1:0] i_reg_wdata,
	input  wire logic                                 i_reg_write,
	input  wire logic                                 i_reg_read,
	output logic [flash_host_pkg::REG_DATA_W-1:0]      o_reg_rdata,
	// flash pins
	output logic [flash_host_pkg::ADDR_W-1:0]          o_address_lines,
	input  wire logic [flash_host_pkg::DATA_W-1:0]     i_data_lines,
	output logic [flash_host_pkg::DATA_W-1:0]          o_data_lines,
	output logic                                      o_data_lines_oe_n,
	output logic                                      o_device_select_n,
	output logic                                      o_output_gate_n,
	output logic                                      o_write_strobe_n,
	output logic                                      o_id_high_voltage
);
	import flash_host_pkg::*;

	if (LOAD_TIMEOUT < LOAD_TIMEOUT_CYC / 1000 + 1 || POLL_LIMIT < 2) begin : g_bad_counts
		$error("flash_host_ctrl: count parameters too small");
	end

	// page buffer and its loaded marks
	logic [DATA_W-1:0]     page_buf [PAGE_BYTES];
	logic [PAGE_BYTES-1:0] loaded;

	// registers
	seq_state_t          state;
	logic [2:0]          op;
	logic                unlock;
	logic                high_voltage;
	logic [ADDR_W-1:0]   addr;
	logic                busy;
	logic                timeout_err;
	logic                poll_ok;
	logic [DATA_W-1:0]   read_data;
	logic [3:0]          step;
	logic [OFFSET_W:0]   scan;
	logic [31:0]         wait_count;
	logic                cyc_pending;
	logic                poll_second;
	logic                last_toggle;
	logic [ADDR_W-1:0]   last_addr;
	logic [DATA_W-1:0]   last_data;

	// bus cycle request
	logic                cyc_start;
	logic                cyc_write;
	logic [ADDR_W-1:0]   cyc_addr;
	logic [DATA_W-1:0]   cyc_data;
	logic                cyc_done;
	logic [DATA_W-1:0]   cyc_rdata;

	// decoded strobes
	logic ctrl_write;
	logic buf_write;
	logic addr_write;
	logic [2:0] new_op;
	logic [OFFSET_W-1:0] buf_offset;

	assign ctrl_write = i_reg_write && i_reg_addr == REG_CTRL;
	assign buf_write  = i_reg_write && i_reg_addr == REG_BUF;
	assign addr_write = i_reg_write && i_reg_addr == REG_ADDR;
	assign new_op     = i_reg_wdata[CTRL_OP_LSB +: CTRL_OP_W];
	assign buf_offset = i_reg_wdata[BUF_OFFSET_LSB +: OFFSET_W];

	// command table lookups
	function automatic logic [3:0] cmd_len(input logic [2:0] f_op, input logic f_unlock);
		case (f_op)
			OP_PROGRAM:  cmd_len = f_unlock ? LEN_SHORT : 4'h0;
			OP_ID_EXIT:  cmd_len = LEN_SHORT;
			OP_ERASE,
			OP_ID_ENTER,
			OP_UNPROTECT: cmd_len = LEN_LONG;
			default:     cmd_len = 4'h0;
		endcase
	endfunction

	function automatic logic [ADDR_W-1:0] cmd_addr(input logic [3:0] f_step);
		// second and fifth bytes go to the second address; low 15 bits matter
		cmd_addr = (f_step == 4'h1 || f_step == 4'h4) ? CMD_ADDR_B : CMD_ADDR_A;
	endfunction

	function automatic logic [DATA_W-1:0] cmd_data(input logic [2:0] f_op, input logic [3:0] f_step);
		case (f_step)
			4'h0, 4'h3: cmd_data = CMD_FIRST;
			4'h1, 4'h4: cmd_data = CMD_SECOND;
			4'h2: begin
				case (f_op)
					OP_PROGRAM: cmd_data = CMD_PROTECT;
					OP_ID_EXIT: cmd_data = CMD_ID_EXIT;
					default:    cmd_data = CMD_EXTEND;
				endcase
			end
			default: begin
				case (f_op)
					OP_ERASE:    cmd_data = CMD_ERASE;
					OP_ID_ENTER: cmd_data = CMD_ID_ENTER;
					default:     cmd_data = CMD_DISABLE;
				endcase
			end
		endcase
	endfunction

	// request to the bus cycle engine for the current state
	always_comb begin
		cyc_start = 1'b0;
		cyc_write = 1'b1;
		cyc_addr  = cmd_addr(step);
		cyc_data  = cmd_data(op, step);
		case (state)
			SEQ_CMD: begin
				cyc_start = !cyc_pending && step != cmd_len(op, unlock);
			end
			SEQ_LOAD: begin
				// page from the address register, byte from the scan
				cyc_start = !cyc_pending && !scan[OFFSET_W] && loaded[scan[OFFSET_W-1:0]];
				cyc_addr  = {addr[ADDR_W-1:OFFSET_W], scan[OFFSET_W-1:0]};
				cyc_data  = page_buf[scan[OFFSET_W-1:0]];
			end
			SEQ_READ, SEQ_POLL: begin
				cyc_start = !cyc_pending;
				cyc_write = 1'b0;
				cyc_addr  = (state == SEQ_POLL) ? last_addr : addr;
				cyc_data  = ERASED_BYTE;
			end
			default: cyc_start = 1'b0;
		endcase
	end

	// page buffer fill from software, any offset in any order
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			loaded <= '0;
		end else if (buf_write && !busy) begin
			loaded[buf_offset] <= 1'b1;
		end else if ((ctrl_write && !busy && i_reg_wdata[CTRL_CLEAR_BIT])
			     || (state == SEQ_LOAD && scan[OFFSET_W])) begin
			loaded <= '0;
		end
	end

	// buffer storage needs no reset: only marked bytes are ever sent
	always_ff @(posedge i_clock) begin
		if (buf_write && !busy) begin
			page_buf[buf_offset] <= i_reg_wdata[BUF_DATA_LSB +: DATA_W];
		end
	end

	// software settings
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			addr         <= '0;
			unlock       <= 1'b1;
			high_voltage <= 1'b0;
		end else if (!busy) begin
			if (addr_write) begin
				addr <= i_reg_wdata[ADDR_W-1:0];
			end
			if (ctrl_write) begin
				unlock       <= i_reg_wdata[CTRL_UNLOCK_BIT];
				high_voltage <= i_reg_wdata[CTRL_HV_BIT];
			end
		end
	end

	// raised identification voltage follows the HV control bit, which can only change while no operation runs
	assign o_id_high_voltage = high_voltage;

	// operation sequencer
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state       <= SEQ_IDLE;
			op          <= OP_NONE;
			busy        <= 1'b0;
			step        <= 4'h0;
			scan        <= '0;
			wait_count  <= 32'h0;
			cyc_pending <= 1'b0;
			poll_second <= 1'b0;
			timeout_err <= 1'b0;
			poll_ok     <= 1'b0;
			last_toggle <= 1'b0;
			read_data   <= '0;
			last_addr   <= '0;
			last_data   <= '0;
		end else begin
			if (cyc_start) begin
				cyc_pending <= 1'b1;
			end else if (cyc_done) begin
				cyc_pending <= 1'b0;
			end
			case (state)
				SEQ_IDLE: begin
					// new orders only once the device is idle again
					if (ctrl_write && new_op != OP_NONE && new_op <= OP_UNPROTECT) begin
						op          <= new_op;
						busy        <= 1'b1;
						step        <= 4'h0;
						scan        <= '0;
						wait_count  <= 32'h0;
						timeout_err <= 1'b0;
						poll_second <= 1'b0;
						state       <= (new_op == OP_READ) ? SEQ_READ : SEQ_CMD;
					end
				end
				SEQ_CMD: begin
					if (cyc_done) begin
						step <= step + 4'h1;
					end else if (!cyc_pending && step == cmd_len(op, unlock)) begin
						if (op == OP_PROGRAM) begin
							state <= SEQ_LOAD;
						end else if (op == OP_ID_ENTER || op == OP_ID_EXIT) begin
							wait_count <= ID_PAUSE_CYC;
							state      <= SEQ_SETTLE;
						end else begin
							// erase and disable run self-timed, then poll
							last_addr  <= '0;
							wait_count <= 32'h0;
							state      <= SEQ_POLL;
						end
					end
				end
				SEQ_LOAD: begin
					// bytes go out back to back, far inside the load window
					if (cyc_done) begin
						last_addr <= cyc_addr;
						last_data <= cyc_data;
						scan      <= scan + 1'b1;
					end else if (!cyc_pending && !scan[OFFSET_W]
						     && !loaded[scan[OFFSET_W-1:0]]) begin
						scan <= scan + 1'b1;
					end else if (!cyc_pending && scan[OFFSET_W]) begin
						// quiet bus lets the device close the page itself
						wait_count <= LOAD_TIMEOUT;
						state      <= SEQ_SETTLE;
					end
				end
				SEQ_SETTLE: begin
					if (wait_count != 32'h0) begin
						wait_count <= wait_count - 32'h1;
					end else if (op == OP_PROGRAM) begin
						state <= SEQ_POLL;
					end else begin
						busy  <= 1'b0;
						state <= SEQ_IDLE;
					end
				end
				SEQ_READ: begin
					if (cyc_done) begin
						read_data <= cyc_rdata;
						busy      <= 1'b0;
						state     <= SEQ_IDLE;
					end
				end
				SEQ_POLL: begin
					// two reads in a row agreeing on the toggle bit: done
					if (cyc_done) begin
						last_toggle <= cyc_rdata[6];
						poll_second <= 1'b1;
						read_data   <= cyc_rdata;
						wait_count  <= wait_count + 32'h1;
						if (poll_second && cyc_rdata[6] == last_toggle) begin
							poll_ok <= cyc_rdata[7] == last_data[7];
							busy    <= 1'b0;
							state   <= SEQ_IDLE;
						end else if (wait_count == 32'(POLL_LIMIT - 1)) begin
							timeout_err <= 1'b1;
							busy        <= 1'b0;
							state       <= SEQ_IDLE;
						end
					end
					// wait_count counts finished polls so a stuck device cannot hang us
				end
				default: state <= SEQ_IDLE;
			endcase
		end
	end

	// register read port, answer in the following cycle
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_reg_rdata <= '0;
		end else if (i_reg_read) begin
			case (i_reg_addr)
				REG_CTRL: begin
					o_reg_rdata <= 32'({high_voltage, unlock, 1'b0, op});
				end
				REG_ADDR:   o_reg_rdata <= 32'(addr);
				REG_STATUS: begin
					o_reg_rdata <= 32'({unlock, poll_ok, high_voltage, timeout_err, busy});
				end
				REG_RDATA:  o_reg_rdata <= 32'(read_data);
				default:    o_reg_rdata <= 32'h0;
			endcase
		end else begin
			o_reg_rdata <= 32'h0;
		end
	end

	// single bus cycles on the flash pins; one at a time keeps gate and
	// strobe from ever being low together
	flash_bus_cycle #(
		.PULSE_CYC (STROBE_CYC)
	) u_cycle (
		.i_clock           (i_clock),
		.i_reset_n         (i_reset_n),
		.i_start           (cyc_start),
		.i_write           (cyc_write),
		.i_addr            (cyc_addr),
		.i_data            (cyc_data),
		.o_done            (cyc_done),
		.o_rdata           (cyc_rdata),
		.o_address_lines   (o_address_lines),
		.i_data_lines      (i_data_lines),
		.o_data_lines      (o_data_lines),
		.o_data_lines_oe_n (o_data_lines_oe_n),
		.o_device_select_n (o_device_select_n),
		.o_output_gate_n   (o_output_gate_n),
		.o_write_strobe_n  (o_write_strobe_n)
	);

endmodule

// ===== pkg/flash_host_pkg.sv
// constants for the page flash host controller: register map, command
// tables and timing counts; assumes a 40 MHz system clock
package flash_host_pkg;

	// clock and widths
	localparam int unsigned CLOCK_MHZ    = 40;
	localparam int unsigned ADDR_W       = 17;
	localparam int unsigned DATA_W       = 8;
	localparam int unsigned PAGE_BYTES   = 128;
	localparam int unsigned OFFSET_W     = 7;
	localparam int unsigned REG_ADDR_W   = 8;
	localparam int unsigned REG_DATA_W   = 32;

	// register offsets of the software port
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_ADDR   = 8'h04;
	localparam logic [7:0] REG_BUF    = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0C;
	localparam logic [7:0] REG_RDATA  = 8'h10;

	// control word fields
	localparam int unsigned CTRL_OP_LSB     = 0;
	localparam int unsigned CTRL_OP_W       = 3;
	localparam int unsigned CTRL_UNLOCK_BIT = 4;
	localparam int unsigned CTRL_HV_BIT     = 5;
	localparam int unsigned CTRL_CLEAR_BIT  = 6;

	// buffer word fields
	localparam int unsigned BUF_DATA_LSB   = 0;
	localparam int unsigned BUF_OFFSET_LSB = 8;

	// status word fields
	localparam int unsigned STAT_BUSY_BIT    = 0;
	localparam int unsigned STAT_TIMEOUT_BIT = 1;
	localparam int unsigned STAT_HV_BIT      = 2;
	localparam int unsigned STAT_POLL_BIT    = 3;
	localparam int unsigned STAT_UNLOCK_BIT  = 4;

	// operation codes written to the control word
	localparam logic [2:0] OP_NONE      = 3'h0;
	localparam logic [2:0] OP_READ      = 3'h1;
	localparam logic [2:0] OP_PROGRAM   = 3'h2;
	localparam logic [2:0] OP_ERASE     = 3'h3;
	localparam logic [2:0] OP_ID_ENTER  = 3'h4;
	localparam logic [2:0] OP_ID_EXIT   = 3'h5;
	localparam logic [2:0] OP_UNPROTECT = 3'h6;

	// command addresses and data bytes
	localparam logic [16:0] CMD_ADDR_A   = 17'h05555;
	localparam logic [16:0] CMD_ADDR_B   = 17'h02AAA;
	localparam logic [7:0]  CMD_FIRST    = 8'hAA;
	localparam logic [7:0]  CMD_SECOND   = 8'h55;
	localparam logic [7:0]  CMD_PROTECT  = 8'hA0;
	localparam logic [7:0]  CMD_EXTEND   = 8'h80;
	localparam logic [7:0]  CMD_DISABLE  = 8'h20;
	localparam logic [7:0]  CMD_ERASE    = 8'h10;
	localparam logic [7:0]  CMD_ID_ENTER = 8'h60;
	localparam logic [7:0]  CMD_ID_EXIT  = 8'hF0;
	localparam logic [7:0]  ERASED_BYTE  = 8'hFF;
	localparam logic [3:0]  LEN_SHORT    = 4'h3;
	localparam logic [3:0]  LEN_LONG     = 4'h6;

	// timing in printed units and in cycles
	localparam int unsigned STROBE_NS          = 100;
	localparam int unsigned STROBE_CYC         = (STROBE_NS * CLOCK_MHZ + 999) / 1000;
	localparam int unsigned BYTE_LOAD_WINDOW_US = 200;
	localparam int unsigned BYTE_LOAD_WINDOW_CYC = BYTE_LOAD_WINDOW_US * CLOCK_MHZ;
	localparam int unsigned LOAD_TIMEOUT_US    = 300;
	localparam int unsigned LOAD_TIMEOUT_CYC   = LOAD_TIMEOUT_US * CLOCK_MHZ;
	localparam int unsigned ID_PAUSE_US        = 10;
	localparam int unsigned ID_PAUSE_CYC       = ID_PAUSE_US * CLOCK_MHZ;
	localparam int unsigned ERASE_MS           = 50;
	localparam int unsigned ERASE_CYC          = ERASE_MS * 1000 * CLOCK_MHZ;

	// sequencer states
	typedef enum logic [2:0] {
		SEQ_IDLE, SEQ_CMD, SEQ_LOAD, SEQ_READ, SEQ_SETTLE, SEQ_POLL
	} seq_state_t;

	// single bus cycle phases
	typedef enum logic [1:0] {
		CYC_IDLE, CYC_SETUP, CYC_STROBE, CYC_HOLD
	} cyc_state_t;

endpackage

// ===== hdl/flash_bus_cycle.sv
// one asynchronous read or write cycle on the flash pins
// assumes start is only raised while o_done has finished the previous cycle
`timescale 1ns/1ps
module flash_bus_cycle #(
	parameter int unsigned PULSE_CYC = flash_host_pkg::STROBE_CYC
) (
	// clock and reset
	input  wire logic                             i_clock,
	input  wire logic                             i_reset_n,
	// request
	input  wire logic                             i_start,
	input  wire logic                             i_write,
	input  wire logic [flash_host_pkg::ADDR_W-1:0] i_addr,
	input  wire logic [flash_host_pkg::DATA_W-1:0] i_data,
	output logic                                  o_done,
	output logic [flash_host_pkg::DATA_W-1:0]      o_rdata,
	// flash pins
	output logic [flash_host_pkg::ADDR_W-1:0]      o_address_lines,
	input  wire logic [flash_host_pkg::DATA_W-1:0] i_data_lines,
	output logic [flash_host_pkg::DATA_W-1:0]      o_data_lines,
	output logic                                  o_data_lines_oe_n,
	output logic                                  o_device_select_n,
	output logic                                  o_output_gate_n,
	output logic                                  o_write_strobe_n
);
	import flash_host_pkg::*;

	if (PULSE_CYC < 1 || PULSE_CYC > 255) begin : g_bad_pulse
		$error("flash_bus_cycle: PULSE_CYC out of range");
	end

	cyc_state_t state;
	logic [7:0] count;
	logic       is_write;

	// phase sequencing: select low first, then the strobe, then all high
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state             <= CYC_IDLE;
			count             <= 8'h00;
			is_write          <= 1'b0;
			o_done            <= 1'b0;
			o_device_select_n <= 1'b1;
			o_output_gate_n   <= 1'b1;
			o_write_strobe_n  <= 1'b1;
			o_data_lines_oe_n <= 1'b1;
		end else begin
			o_done <= 1'b0;
			case (state)
				CYC_IDLE: begin
					if (i_start) begin
						is_write          <= i_write;
						o_device_select_n <= 1'b0;
						o_data_lines_oe_n <= ~i_write;
						state             <= CYC_SETUP;
					end
				end
				CYC_SETUP: begin
					// gate stays high for writes and strobe stays high for reads
					o_write_strobe_n <= ~is_write;
					o_output_gate_n  <= is_write;
					count            <= 8'(PULSE_CYC - 1);
					state            <= CYC_STROBE;
				end
				CYC_STROBE: begin
					// pulse of several cycles, far above the glitch filter
					if (count == 8'h00) begin
						o_write_strobe_n  <= 1'b1;
						o_output_gate_n   <= 1'b1;
						o_device_select_n <= 1'b1;
						state             <= CYC_HOLD;
					end else begin
						count <= count - 8'h01;
					end
				end
				CYC_HOLD: begin
					// data still driven one cycle past the rising edges
					o_data_lines_oe_n <= 1'b1;
					o_done            <= 1'b1;
					state             <= CYC_IDLE;
				end
				default: state <= CYC_IDLE;
			endcase
		end
	end

	// address and data registered as select falls, held stable from before the strobe or gate falls
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_address_lines <= '0;
			o_data_lines    <= '0;
		end else if (state == CYC_IDLE && i_start) begin
			o_address_lines <= i_addr;
			o_data_lines    <= i_data;
		end
	end

	// read data sampled while gate and select are still low
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_rdata <= '0;
		end else if (state == CYC_STROBE && count == 8'h00 && !is_write) begin
			o_rdata <= i_data_lines;
		end
	end

endmodule

// ===== test/flash_host_sva.sv
// pin and register port assertions for the flash host controller
// assumes the default strobe width of four cycles
`timescale 1ns/1ps
module flash_host_sva (
	// clock, reset, register port
	input wire logic                                  i_clock,
	input wire logic                                  i_reset_n,
	input wire logic                                  i_reg_read,
	input wire logic [flash_host_pkg::REG_DATA_W-1:0] o_reg_rdata,
	// flash pins
	input wire logic [flash_host_pkg::ADDR_W-1:0]     o_address_lines,
	input wire logic [flash_host_pkg::DATA_W-1:0]     o_data_lines,
	input wire logic                                  o_data_lines_oe_n,
	input wire logic                                  o_device_select_n,
	input wire logic                                  o_output_gate_n,
	input wire logic                                  o_write_strobe_n
);
	import flash_host_pkg::*;
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_reset_n);
	// every command prefix opens with these two bytes
	sequence s_first;
		$fell(o_write_strobe_n) && o_address_lines == CMD_ADDR_A && o_data_lines == CMD_FIRST;
	endsequence
	sequence s_second;
		##[2:12] $fell(o_write_strobe_n) && o_address_lines == CMD_ADDR_B
			&& o_data_lines == CMD_SECOND;
	endsequence
	chk_no_overlap: assert property (!(!o_output_gate_n && !o_write_strobe_n))
		else $error("gate and write strobe low together");
	chk_write_qual: assert property (!o_write_strobe_n |->
		!o_device_select_n && o_output_gate_n && !o_data_lines_oe_n)
		else $error("write strobe without select or data");
	chk_read_release: assert property (!o_output_gate_n |->
		o_data_lines_oe_n && !o_device_select_n)
		else $error("host drives data while flash output gated");
	chk_strobe_width: assert property ($fell(o_write_strobe_n) |-> (!o_write_strobe_n)[*4])
		else $error("write strobe too short");
	chk_addr_held: assert property (!o_write_strobe_n && !$past(o_write_strobe_n) |->
		$stable(o_address_lines))
		else $error("address moved during write strobe");
	chk_data_held: assert property ($rose(o_write_strobe_n) |->
		$stable(o_data_lines) && !o_data_lines_oe_n)
		else $error("data not held at strobe rise");
	chk_select_pair: assert property ($rose(o_write_strobe_n) |-> $rose(o_device_select_n))
		else $error("select not released with strobe");
	chk_cmd_pair: assert property (s_first |-> s_second)
		else $error("command prefix out of order");
	chk_rdata_idle: assert property (!$past(i_reg_read) |-> o_reg_rdata == '0)
		else $error("read data outside its cycle");
endmodule
bind flash_host_ctrl flash_host_sva chk_u (.i_clock(i_clock), .i_reset_n(i_reset_n),
	.i_reg_read(i_reg_read), .o_reg_rdata(o_reg_rdata), .o_address_lines(o_address_lines),
	.o_data_lines(o_data_lines), .o_data_lines_oe_n(o_data_lines_oe_n),
	.o_device_select_n(o_device_select_n), .o_output_gate_n(o_output_gate_n),
	.o_write_strobe_n(o_write_strobe_n));

// ===== test/flash_dev_model.sv
// behavioural page flash device on the far side of the pins
// assumes the clock only times the load window and the busy period
`timescale 1ns/1ps
module flash_dev_model #(
	parameter logic [7:0] MAKER = 8'h3C, // arbitrary
	parameter logic [7:0] PART  = 8'h5A, // arbitrary
	parameter int         LT    = 14,
	parameter int         PT    = 30
) (
	input  wire logic        i_clock,
	input  wire logic [16:0] i_addr,
	input  wire logic [7:0]  i_dq,
	input  wire logic        i_cs_n,
	input  wire logic        i_gate_n,
	input  wire logic        i_we_n,
	input  wire logic        i_hv,
	output logic [7:0]       o_q
);
	logic [7:0]   mem [int];
	logic [7:0]   pbuf [128];
	logic [127:0] mark;
	logic [47:0]  hd;
	logic [5:0]   ha = '0;
	logic         supply_low = 1'b0;
	logic [16:0]  la;
	logic [9:0]   page;
	logic [7:0]   ld, rv, held = 8'h00;
	logic         prot = 1'b1;
	logic         open = 1'b0, id = 1'b0, wr = 1'b0, tog = 1'b0;
	int           tmr = 0, busy = 0;
	realtime      t0;
	task automatic take(input logic [16:0] a, input logic [7:0] d);
		tmr = 0;
		if (a[14:0] == 15'h5555 || a[14:0] == 15'h2AAA) begin
			hd = {hd[39:0], d};
			ha = {ha[4:0], a[14:0] == 15'h2AAA};
			if (hd[23:0] == 24'hAA55A0 && ha[2:0] == 3'b010) begin
				prot = 1'b1;
				open = 1'b1;
				mark = '0;
			end
			if (hd[23:0] == 24'hAA55F0 && ha[2:0] == 3'b010) id = 1'b0;
			if (hd == 48'hAA5580AA5520 && ha == 6'b010010) prot = 1'b0;
			if (hd == 48'hAA5580AA5510 && ha == 6'b010010) begin
				mem.delete();
				busy = PT;
			end
			if (hd == 48'hAA5580AA5560 && ha == 6'b010010) id = 1'b1;
		end else if (!prot || open) begin
			if (!open) mark = '0;
			open = 1'b1;
			page = a[16:7];
			pbuf[a[6:0]] = d;
			mark[a[6:0]] = 1'b1;
			ld = d;
		end
	endtask
	// address on the later fall, refused while gated or busy
	always @(negedge i_we_n or negedge i_cs_n)
		if (!i_we_n && !i_cs_n && i_gate_n) begin
			la = i_addr;
			wr = 1'b1;
			t0 = $realtime;
		end
	always @(posedge i_we_n or posedge i_cs_n)
		if (wr) begin
			wr = 1'b0;
			if ($realtime - t0 >= 15.0 && busy == 0 && !supply_low) take(la, i_dq);
		end
	// quiet load window closes the page; whole buffer written at once
	always @(posedge i_clock) begin
		if (busy > 0) busy--;
		if (open && i_we_n && ++tmr >= LT) begin
			open = 1'b0;
			busy = PT;
			for (int i = 0; i < 128; i++)
				mem[{page, i[6:0]}] = mark[i] ? pbuf[i] : 8'hFF;
		end
	end
	always @(negedge i_gate_n)
		if (!i_cs_n) begin
			if (busy > 0) begin
				rv = {~ld[7], tog, ld[5:0]};
				tog = ~tog;
			end else if (id || i_hv) rv = i_addr[0] ? PART : MAKER;
			else rv = mem.exists(int'(i_addr)) ? mem[int'(i_addr)] : 8'hFF;
		end
	// a released bus must not keep showing the last byte
	always @(posedge i_gate_n or posedge i_cs_n) held = ~rv;
	assign o_q = (!i_cs_n && !i_gate_n) ? rv : held;
endmodule

// ===== test/tb_top.sv
// self-checking bench: controller driving the behavioural flash model
// assumes shortened load and poll counts on both sides
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
	$display("[ERR] %0t got %h want %h", $time, g, e); end end
module tb_top;
	import flash_host_pkg::*;
	logic        i_clock = 1'b0, i_reset_n = 1'b0, i_reg_write = 1'b0, i_reg_read = 1'b0;
	logic [7:0]  i_reg_addr = 8'h00, o_data_lines, mq;
	logic [31:0] i_reg_wdata = 32'h0, o_reg_rdata, v;
	logic [16:0] o_address_lines;
	logic        oe_n, cs_n, og_n, we_n, hv;
	wire  [7:0]  dq = !oe_n ? o_data_lines : mq; // resolved data pins
	int          err_count = 0, cmp_count = 0, cyc = 0;
	flash_host_ctrl #(.LOAD_TIMEOUT(30), .POLL_LIMIT(50)) dut_u (.i_clock(i_clock),
		.i_reset_n(i_reset_n), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
		.i_reg_write(i_reg_write), .i_reg_read(i_reg_read), .o_reg_rdata(o_reg_rdata),
		.o_address_lines(o_address_lines), .i_data_lines(dq), .o_data_lines(o_data_lines),
		.o_data_lines_oe_n(oe_n), .o_device_select_n(cs_n), .o_output_gate_n(og_n),
		.o_write_strobe_n(we_n), .o_id_high_voltage(hv));
	flash_dev_model #(.LT(14), .PT(30)) dev_u (.i_clock(i_clock), .i_addr(o_address_lines),
		.i_dq(dq), .i_cs_n(cs_n), .i_gate_n(og_n), .i_we_n(we_n), .i_hv(hv), .o_q(mq));
	initial forever #12.5 i_clock = ~i_clock;
	// hang guard
	always @(posedge i_clock) if (++cyc == 40000) begin
		err_count++;
		$display("[ERR] %0t timeout", $time);
		results();
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clock);
		i_reg_addr <= a;
		i_reg_wdata <= d;
		i_reg_write <= 1'b1;
		@(posedge i_clock);
		i_reg_write <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] r);
		@(posedge i_clock);
		i_reg_addr <= a;
		i_reg_read <= 1'b1;
		@(posedge i_clock);
		i_reg_read <= 1'b0;
		#1;
		r = o_reg_rdata;
	endtask
	// start an operation and poll busy under a bound
	task automatic run(input logic [31:0] c);
		wr(REG_CTRL, c);
		for (int i = 0; i < 1000; i++) begin
			rd(REG_STATUS, v);
			if (v[STAT_BUSY_BIT] === 1'b0) break;
		end
	endtask
	task automatic peek(input logic [16:0] a, input logic [31:0] c, input logic [7:0] e);
		wr(REG_ADDR, {15'h0, a});
		run(c | 32'h1);
		rd(REG_RDATA, v);
		`CHK(v[7:0], e)
	endtask
	task automatic results();
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge i_clock);
		i_reset_n <= 1'b1;
		rd(REG_STATUS, v);
		`CHK(v, 32'h0000_0010)
		rd(8'h20, v);
		`CHK(v, 32'h0)
		// unlocked page load, offsets out of order
		wr(REG_ADDR, 32'h0000_0080);
		wr(REG_BUF, 32'h0000_053C);
		wr(REG_BUF, 32'h0000_02C3);
		run(32'h12);
		rd(REG_STATUS, v);
		`CHK(v[STAT_POLL_BIT], 1'b1)
		peek(17'h00085, 32'h0, 8'h3C);
		peek(17'h00082, 32'h0, 8'hC3);
		peek(17'h00080, 32'h0, 8'hFF);
		// plain load while protected is dropped
		wr(REG_CTRL, 32'h40);
		wr(REG_ADDR, 32'h0000_0100);
		wr(REG_BUF, 32'h0000_0011);
		run(32'h02);
		peek(17'h00100, 32'h0, 8'hFF);
		run(32'h06);
		`CHK(dev_u.prot, 1'b0)
		wr(REG_CTRL, 32'h40);
		wr(REG_BUF, 32'h0000_0011);
		run(32'h02);
		peek(17'h00100, 32'h0, 8'h11);
		run(32'h03);
		peek(17'h00085, 32'h0, 8'hFF);
		run(32'h04);
		peek(17'h00000, 32'h0, 8'h3C);
		peek(17'h00001, 32'h0, 8'h5A);
		run(32'h05);
		peek(17'h00001, 32'h0, 8'hFF);
		peek(17'h00001, 32'h20, 8'h5A);
		rd(REG_STATUS, v);
		`CHK(v[2:0], 3'b100)
		`CHK(hv, 1'b1)
		results();
	end
endmodule
